// file: t8wm_params.svh
// Register offsets, field positions, reset values and count limits of the 8-bit timer
`ifndef T8WM_PARAMS_SVH
`define T8WM_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define T8WM_OFF_CTRL 12'h000
`define T8WM_OFF_COUNT 12'h004
`define T8WM_OFF_CMP 12'h008
`define T8WM_OFF_FLAGS 12'h00c

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define T8WM_CTRL_MODE_LSB 0
`define T8WM_CTRL_ACT_LSB 2
`define T8WM_CTRL_CLK_LSB 4
`define T8WM_CTRL_DIR_BIT 7
`define T8WM_CTRL_PORT_BIT 8
`define T8WM_FLAG_OVF_BIT 0
`define T8WM_FLAG_MATCH_BIT 1

// ----------------------------------------
// Count limits and reset values
// ----------------------------------------
`define T8WM_MAX 8'hff
`define T8WM_BOTTOM 8'h00
`define T8WM_CNT_RST 8'h00
`define T8WM_CMP_RST 8'h00
`define T8WM_PRESC_W 10

`endif

// file: t8wm_pkg.sv
// Types shared by the 8-bit waveform timer
package t8wm_pkg;

	typedef enum logic [1:0] {
		T8WM_NORMAL = 2'b00,
		T8WM_PHASE = 2'b01,
		T8WM_CLEAR = 2'b10,
		T8WM_FAST = 2'b11
	} t8wm_mode_t;

	typedef struct packed {
		t8wm_mode_t waveModeSel;
		logic [1:0] cmpOutAction;
		logic [2:0] clkSel;
		logic pinDir;
		logic portLevel;
	} t8wm_ctrl_t;

	typedef struct packed {
		t8wm_ctrl_t ctrl;
		logic [9:0] prescCnt;
		logic [7:0] countValue;
		logic [7:0] compareLevel;
		logic [7:0] compareBuf;
		logic countDown;
		logic blockMatch;
		logic compareOutput;
		logic overflowFlag;
		logic matchFlag;
		logic [31:0] rdData;
		logic rdErr;
	} t8wm_state_t;

endpackage

// file: t8wm_timer.sv
// 8-bit timer/counter with one compare channel, four waveform modes and an APB slave
//
// How it works
// - Normal mode counts up only, no match clear, wraps ff to 00.
// - Normal mode sets overflow flag as count becomes zero; only a write of one or ovfAck clears it.
// - Normal mode accepts count writes at any time.
// - Mode 2 clears the count on a match; compare level is top.
// - Mode 2 compare level is written directly; below count means wrap first.
// - Mode 2 with action 1 toggles the output on every match.
// - Mode 2 sets overflow flag when the count passes ff to 00 without a match.
// - Timer tick is the clock divided by 1, 8, 32, 64, 128, 256, 1024.
// - Mode 3 counts zero to ff, then clears on the next tick.
// - Mode 3 action 2 clears on match, sets at bottom; action 3 opposite.
// - Mode 3 sets the overflow flag when the count reaches ff.
// - Mode 3 output period is 256 ticks.
// - Mode 3 level zero gives a one-tick spike; level ff a constant.
// - Mode 3 action 1 toggles on match with buffered compare level.
// - Mode 1 counts up to ff, holds it one tick, counts down.
// - Mode 1 action 2 clears on up match, sets on down; 3 inverts.
// - Mode 1 sets the overflow flag when the count reaches zero.
// - Mode 1 output period is 510 ticks, eight bits fixed.
// - Only the mode field shapes counting; action field shapes only the output.
// - The pin shows the compare output only while the action field is nonzero; its enable follows the direction bit.
// - Match flag sets on the clock after a match; cleared by one or acknowledge.
// - PWM modes load the compare level at the top; others load at once.
// - A count write blocks any match in the next timer cycle.
`include "t8wm_params.svh"

module t8wm_timer
	import t8wm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flag acknowledges from the interrupt controller
	input wire logic ovfAck,
	input wire logic matchAck,
	// Port pin and flag outputs
	output logic compareOutPin,
	output logic compareOutPinOe,
	output logic overflowFlag,
	output logic matchFlag
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Prescaler mask: tick when all masked low bits are ones
	function automatic logic [9:0] prescMask(input logic [2:0] sel);
		case (sel)
			3'h1: prescMask = 10'h000;
			3'h2: prescMask = 10'h007;
			3'h3: prescMask = 10'h01f;
			3'h4: prescMask = 10'h03f;
			3'h5: prescMask = 10'h07f;
			3'h6: prescMask = 10'h0ff;
			3'h7: prescMask = 10'h3ff;
			default: prescMask = 10'h000;
		endcase
	endfunction

	function automatic logic isMapped(input logic [11:0] a);
		isMapped = (a == `T8WM_OFF_CTRL) || (a == `T8WM_OFF_COUNT) ||
			(a == `T8WM_OFF_CMP) || (a == `T8WM_OFF_FLAGS);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	t8wm_state_t st_reg;
	t8wm_state_t st_next;
	logic tick;
	logic wrAcc;
	logic setupRd;
	logic cntWr;
	logic matchLive;
	logic matchEv;
	logic atMax;
	logic pwmMode;
	logic downMatch;
	logic ovfSet;
	logic matchSet;
	logic [31:0] rdMux;

	assign wrAcc = psel && penable && pwrite;
	assign setupRd = psel && !penable;
	assign cntWr = wrAcc && (paddr == `T8WM_OFF_COUNT);
	assign tick = (st_reg.ctrl.clkSel != 3'h0) &&
		((st_reg.prescCnt & prescMask(st_reg.ctrl.clkSel)) ==
		prescMask(st_reg.ctrl.clkSel));
	assign atMax = (st_reg.countValue == `T8WM_MAX);
	assign pwmMode = (st_reg.ctrl.waveModeSel == T8WM_FAST) ||
		(st_reg.ctrl.waveModeSel == T8WM_PHASE);
	assign matchLive = (st_reg.countValue == st_reg.compareLevel) && !st_reg.blockMatch;
	assign matchEv = tick && matchLive && !cntWr;
	// At the top a phase-correct match counts as down so that ff holds high
	assign downMatch = (st_reg.countDown && (st_reg.countValue != `T8WM_BOTTOM)) || atMax;

	// ----------------------------------------
	// Read data mux
	// ----------------------------------------
	always_comb
	begin
		rdMux = 32'h0000_0000;
		case (paddr)
			`T8WM_OFF_CTRL:
			begin
				rdMux[`T8WM_CTRL_MODE_LSB +: 2] = st_reg.ctrl.waveModeSel;
				rdMux[`T8WM_CTRL_ACT_LSB +: 2] = st_reg.ctrl.cmpOutAction;
				rdMux[`T8WM_CTRL_CLK_LSB +: 3] = st_reg.ctrl.clkSel;
				rdMux[`T8WM_CTRL_DIR_BIT] = st_reg.ctrl.pinDir;
				rdMux[`T8WM_CTRL_PORT_BIT] = st_reg.ctrl.portLevel;
			end
			`T8WM_OFF_COUNT: rdMux[7:0] = st_reg.countValue;
			`T8WM_OFF_CMP: rdMux[7:0] = st_reg.compareBuf;
			`T8WM_OFF_FLAGS:
			begin
				rdMux[`T8WM_FLAG_OVF_BIT] = st_reg.overflowFlag;
				rdMux[`T8WM_FLAG_MATCH_BIT] = st_reg.matchFlag;
			end
			default: rdMux = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		st_next = st_reg;
		ovfSet = 1'b0;
		matchSet = 1'b0;
		st_next.prescCnt = st_reg.prescCnt + 10'h001;
		if (setupRd)
		begin
			st_next.rdData = rdMux;
			st_next.rdErr = !isMapped(paddr);
		end
		// Counting; the action field is never read here
		if (tick)
		begin
			st_next.blockMatch = 1'b0;
			case (st_reg.ctrl.waveModeSel)
				T8WM_NORMAL:
				begin
					st_next.countValue = st_reg.countValue + 8'h01;
					ovfSet = atMax;
				end
				T8WM_CLEAR:
				begin
					// A level written below the count runs on to ff and wraps
					st_next.countValue = matchLive ? `T8WM_BOTTOM :
						st_reg.countValue + 8'h01;
					ovfSet = atMax && !matchLive;
				end
				T8WM_FAST:
				begin
					st_next.countValue = atMax ? `T8WM_BOTTOM :
						st_reg.countValue + 8'h01;
					ovfSet = (st_reg.countValue == 8'hfe);
				end
				T8WM_PHASE:
				begin
					if (atMax)
					begin
						st_next.countDown = 1'b1;
						st_next.countValue = 8'hfe;
					end
					else if (st_reg.countDown && st_reg.countValue == `T8WM_BOTTOM)
					begin
						st_next.countDown = 1'b0;
						st_next.countValue = 8'h01;
					end
					else if (st_reg.countDown)
					begin
						st_next.countValue = st_reg.countValue - 8'h01;
					end
					else
					begin
						st_next.countValue = st_reg.countValue + 8'h01;
					end
					ovfSet = st_reg.countDown && (st_reg.countValue == 8'h01);
				end
				default: st_next.countValue = st_reg.countValue;
			endcase
			if (st_reg.ctrl.waveModeSel != T8WM_PHASE)
			begin
				st_next.countDown = 1'b0;
			end
			// Buffered level loads at the top of both PWM slopes
			if (pwmMode && atMax)
			begin
				st_next.compareLevel = st_reg.compareBuf;
			end
		end

		// ----------------------------------------
		// Compare output
		// ----------------------------------------
		if (matchEv)
		begin
			matchSet = 1'b1;
		end
		// Output action per mode is decided in one place, below
		st_next.compareOutput = ocNext(st_reg, matchEv, tick, downMatch);

		// ----------------------------------------
		// Register writes, which win over counting
		// ----------------------------------------
		if (wrAcc)
		begin
			case (paddr)
				`T8WM_OFF_CTRL:
				begin
					st_next.ctrl.waveModeSel = t8wm_mode_t'(pwdata[`T8WM_CTRL_MODE_LSB +: 2]);
					st_next.ctrl.cmpOutAction = pwdata[`T8WM_CTRL_ACT_LSB +: 2];
					st_next.ctrl.clkSel = pwdata[`T8WM_CTRL_CLK_LSB +: 3];
					st_next.ctrl.pinDir = pwdata[`T8WM_CTRL_DIR_BIT];
					st_next.ctrl.portLevel = pwdata[`T8WM_CTRL_PORT_BIT];
				end
				`T8WM_OFF_COUNT:
				begin
					st_next.countValue = pwdata[7:0];
					st_next.blockMatch = 1'b1;
				end
				`T8WM_OFF_CMP:
				begin
					st_next.compareBuf = pwdata[7:0];
					if (!pwmMode)
					begin
						st_next.compareLevel = pwdata[7:0];
					end
				end
				`T8WM_OFF_FLAGS:
				begin
					if (pwdata[`T8WM_FLAG_OVF_BIT])
					begin
						st_next.overflowFlag = 1'b0;
					end
					if (pwdata[`T8WM_FLAG_MATCH_BIT])
					begin
						st_next.matchFlag = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (ovfAck)
		begin
			st_next.overflowFlag = 1'b0;
		end
		if (matchAck)
		begin
			st_next.matchFlag = 1'b0;
		end
		// Setting wins over any clear in the same cycle
		if (ovfSet && !cntWr)
		begin
			st_next.overflowFlag = 1'b1;
		end
		if (matchSet)
		begin
			st_next.matchFlag = 1'b1;
		end
	end

	// ----------------------------------------
	// Compare output decision
	// ----------------------------------------
	function automatic logic ocNext(input t8wm_state_t s, input logic m, input logic tk,
		input logic dn);
		logic oc;
		oc = s.compareOutput;
		case (s.ctrl.waveModeSel)
			T8WM_NORMAL, T8WM_CLEAR:
			begin
				if (m)
				begin
					case (s.ctrl.cmpOutAction)
						2'h1: oc = !oc;
						2'h2: oc = 1'b0;
						2'h3: oc = 1'b1;
						default: oc = s.compareOutput;
					endcase
				end
			end
			T8WM_FAST:
			begin
				if (m && s.ctrl.cmpOutAction == 2'h1)
				begin
					oc = !oc;
				end
				else if (m && s.compareLevel != `T8WM_MAX && s.ctrl.cmpOutAction[1])
				begin
					oc = s.ctrl.cmpOutAction[0];
				end
				// Bottom action applied last, so level ff stays constant
				if (tk && s.countValue == `T8WM_MAX && s.ctrl.cmpOutAction[1])
				begin
					oc = !s.ctrl.cmpOutAction[0];
				end
			end
			T8WM_PHASE:
			begin
				if (m && s.ctrl.cmpOutAction[1])
				begin
					oc = dn ? !s.ctrl.cmpOutAction[0] : s.ctrl.cmpOutAction[0];
				end
			end
			default: oc = s.compareOutput;
		endcase
		ocNext = oc;
	endfunction

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pready = 1'b1;
	assign prdata = st_reg.rdData;
	assign pslverr = psel && penable && st_reg.rdErr;
	assign compareOutPin = (st_reg.ctrl.cmpOutAction != 2'h0) ? st_reg.compareOutput :
		st_reg.ctrl.portLevel;
	assign compareOutPinOe = st_reg.ctrl.pinDir;
	assign overflowFlag = st_reg.overflowFlag;
	assign matchFlag = st_reg.matchFlag;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_normal_wrap: assert property (tick && !cntWr && st_reg.ctrl.waveModeSel == T8WM_NORMAL &&
		atMax |=> st_reg.countValue == 8'h00 && st_reg.overflowFlag)
		else $error("normal mode did not wrap with overflow");
	a_normal_up: assert property (tick && !cntWr && st_reg.ctrl.waveModeSel == T8WM_NORMAL |=>
		st_reg.countValue == $past(st_reg.countValue) + 8'h01)
		else $error("normal mode count did not advance by one");
	a_clear_match: assert property (tick && !cntWr && matchLive &&
		st_reg.ctrl.waveModeSel == T8WM_CLEAR |=> st_reg.countValue == 8'h00)
		else $error("clear mode did not clear on match");
	a_clear_toggle: assert property (matchEv && st_reg.ctrl.waveModeSel == T8WM_CLEAR &&
		st_reg.ctrl.cmpOutAction == 2'h1 |=> st_reg.compareOutput != $past(st_reg.compareOutput))
		else $error("clear mode did not toggle output");
	a_fast_top: assert property (tick && !cntWr && st_reg.ctrl.waveModeSel == T8WM_FAST &&
		st_reg.countValue == 8'hfe |=> st_reg.overflowFlag ##0 atMax)
		else $error("fast mode overflow missing at top");
	a_phase_turn: assert property (tick && !cntWr && st_reg.ctrl.waveModeSel == T8WM_PHASE &&
		atMax |=> st_reg.countValue == 8'hfe && st_reg.countDown)
		else $error("phase mode did not turn at top");
	a_phase_bottom: assert property (tick && !cntWr && st_reg.ctrl.waveModeSel == T8WM_PHASE &&
		st_reg.countDown && st_reg.countValue == 8'h01 |=> st_reg.overflowFlag)
		else $error("phase mode overflow missing at bottom");
	a_match_flag: assert property (matchEv |=> st_reg.matchFlag)
		else $error("match flag not set after match");
	a_match_block: assert property ((cntWr || st_reg.blockMatch) && !st_reg.matchFlag |=>
		!st_reg.matchFlag)
		else $error("match not blocked after count write");
	a_pin_dir: assert property (compareOutPinOe == st_reg.ctrl.pinDir)
		else $error("pin enable not following direction");

endmodule // t8wm_timer

// file: t8wm_load.sv
// Load model on the compare output pin: pulled-down pad with edge timing capture
module t8wm_load
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Pin from the timer
	input wire logic pinOut,
	input wire logic pinOe,
	// Measurements
	output logic padLevel,
	output logic [15:0] riseCount,
	output logic [15:0] lastPeriod,
	output logic [15:0] lastHigh
);
	timeunit 1ns;
	timeprecision 1ps;
	logic prevLevel;
	logic [15:0] sinceRise;

	// Pull-down holds the pad low while the timer does not drive it
	assign padLevel = pinOe ? pinOut : 1'b0;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prevLevel <= 1'b0;
			sinceRise <= 16'h0000;
			riseCount <= 16'h0000;
			lastPeriod <= 16'h0000;
			lastHigh <= 16'h0000;
		end
		else
		begin
			prevLevel <= padLevel;
			sinceRise <= sinceRise + 16'h0001;
			if (padLevel && !prevLevel)
			begin
				riseCount <= riseCount + 16'h0001;
				lastPeriod <= sinceRise + 16'h0001;
				sinceRise <= 16'h0000;
			end
			if (!padLevel && prevLevel)
				lastHigh <= sinceRise + 16'h0001;
		end
	end
endmodule // t8wm_load

// file: tb_top.sv
// Self-checking testbench of the 8-bit waveform timer
`include "t8wm_params.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic ovfAck = 1'b0;
	logic matchAck = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic compareOutPin;
	logic compareOutPinOe;
	logic overflowFlag;
	logic matchFlag;
	logic padLevel;
	logic [15:0] riseCount;
	logic [15:0] lastPeriod;
	logic [15:0] lastHigh;
	logic [31:0] rdData;
	logic rdErr;
	int fails = 0;
	int checks = 0;
	int cycles = 0;
	int presc[7] = '{1, 8, 32, 64, 128, 256, 1024};

	t8wm_timer uut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ovfAck(ovfAck), .matchAck(matchAck),
		.compareOutPin(compareOutPin), .compareOutPinOe(compareOutPinOe),
		.overflowFlag(overflowFlag), .matchFlag(matchFlag));

	t8wm_load load (.core_clk(core_clk), .rst_b(rst_b), .pinOut(compareOutPin),
		.pinOe(compareOutPinOe), .padLevel(padLevel), .riseCount(riseCount),
		.lastPeriod(lastPeriod), .lastHigh(lastHigh));

	always #2 core_clk = ~core_clk;

	// Cut a hang short
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			fails++;
			results();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; returns after the edge so flags have settled
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge core_clk);
	endtask

	function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] a,
		input logic [2:0] c, input logic d);
		return (32'(m) << `T8WM_CTRL_MODE_LSB) | (32'(a) << `T8WM_CTRL_ACT_LSB)
			| (32'(c) << `T8WM_CTRL_CLK_LSB) | (32'(d) << `T8WM_CTRL_DIR_BIT);
	endfunction

	task idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task waitRises(input int n);
		int target;
		target = riseCount + n;
		while (riseCount < target)
			@(posedge core_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task testNormal();
		check({31'h0, compareOutPinOe}, 32'h1 - 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		check({31'h0, rdErr}, 32'h1);
		apb(1'b1, `T8WM_OFF_COUNT, 32'hfe);
		apb(1'b1, `T8WM_OFF_CTRL, ctl(2'h0, 2'h0, 3'h1, 1'b0));
		idle(2);
		apb(1'b1, `T8WM_OFF_COUNT, 32'h80);
		apb(1'b1, `T8WM_OFF_CTRL, 32'h0);
		check({31'h0, overflowFlag}, 32'h1);
		apb(1'b0, `T8WM_OFF_COUNT, 32'h0);
		check({28'h0, rdData[7:4]}, 32'h8);
		@(posedge core_clk);
		ovfAck <= 1'b1;
		@(posedge core_clk);
		ovfAck <= 1'b0;
		@(negedge core_clk);
		check({31'h0, overflowFlag}, 32'h0);
		$display("test normal done");
	endtask

	task testBlock();
		apb(1'b1, `T8WM_OFF_FLAGS, 32'h3);
		apb(1'b1, `T8WM_OFF_CMP, 32'h5);
		apb(1'b1, `T8WM_OFF_COUNT, 32'h5);
		apb(1'b1, `T8WM_OFF_CTRL, ctl(2'h0, 2'h0, 3'h1, 1'b0));
		idle(20);
		apb(1'b1, `T8WM_OFF_CTRL, 32'h0);
		check({31'h0, matchFlag}, 32'h0);
		apb(1'b1, `T8WM_OFF_COUNT, 32'h3);
		apb(1'b1, `T8WM_OFF_CTRL, ctl(2'h0, 2'h0, 3'h1, 1'b0));
		idle(20);
		apb(1'b1, `T8WM_OFF_CTRL, 32'h0);
		check({31'h0, matchFlag}, 32'h1);
		apb(1'b1, `T8WM_OFF_FLAGS, 32'h2);
		check({31'h0, matchFlag}, 32'h0);
		$display("test block done");
	endtask

	task testClear();
		apb(1'b1, `T8WM_OFF_CMP, 32'h3);
		foreach (presc[i])
		begin
			apb(1'b1, `T8WM_OFF_CTRL, ctl(2'h2, 2'h1, 3'(i + 1), 1'b1));
			// First rise may come from the old setting or the pin turning on
			waitRises(3);
			check({16'h0, lastPeriod}, 32'(8 * presc[i]));
		end
		apb(1'b1, `T8WM_OFF_CTRL, 32'h0);
		apb(1'b0, `T8WM_OFF_COUNT, 32'h0);
		check({31'h0, rdData[7:0] <= 8'h03}, 32'h1);
		apb(1'b1, `T8WM_OFF_FLAGS, 32'h3);
		apb(1'b1, `T8WM_OFF_COUNT, 32'h10);
		apb(1'b1, `T8WM_OFF_CTRL, ctl(2'h2, 2'h0, 3'h1, 1'b0));
		idle(300);
		apb(1'b1, `T8WM_OFF_CTRL, 32'h0);
		check({31'h0, overflowFlag}, 32'h1);
		apb(1'b1, `T8WM_OFF_CMP, 32'h40);
		$display("test clear done");
	endtask

	task testPwm(input logic [1:0] m, input logic [1:0] a, input int period, input int high);
		apb(1'b1, `T8WM_OFF_CTRL, ctl(m, a, 3'h1, 1'b1));
		apb(1'b1, `T8WM_OFF_FLAGS, 32'h3);
		// First rise may come from the old setting or the pin turning on
		waitRises(3);
		check({16'h0, lastPeriod}, 32'(period));
		check({16'h0, lastHigh}, 32'(high));
		check({31'h0, overflowFlag}, 32'h1);
		$display("test pwm mode %0d action %0d done", m, a);
	endtask

	task testDir();
		logic [15:0] riseBefore;
		apb(1'b1, `T8WM_OFF_CTRL, ctl(2'h3, 2'h2, 3'h1, 1'b0));
		riseBefore = riseCount;
		idle(600);
		check({31'h0, compareOutPinOe}, 32'h0);
		check({16'h0, riseCount}, {16'h0, riseBefore});
		$display("test direction done");
	endtask

	initial
	begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		testNormal();
		testBlock();
		testClear();
		testPwm(2'h3, 2'h2, 256, 65);
		testPwm(2'h3, 2'h3, 256, 191);
		testPwm(2'h1, 2'h2, 510, 128);
		testPwm(2'h1, 2'h3, 510, 382);
		testDir();
		results();
	end
endmodule // tb_top
